/* File: pkg/csq_pkg.sv */
// Shared types and timing constants of the camera-link lane sequencer.
// Assumes the link-side byte clock period given below; all lane intervals
// are derived from it.
`default_nettype none
package csq_pkg;

  // Byte clock of the lane logic, and the unit interval (eight per byte).
  localparam int LINK_PERIOD_PS = 125000;
  localparam int UI_PS          = LINK_PERIOD_PS / 8;
  localparam int TMR_W          = 14;

  // Interval figures in their own units.
  localparam int T_LPX_NS        = 50;
  localparam int T_CLK_PREP_NS   = 38;
  localparam int T_CLK_PZ_NS     = 300;
  localparam int T_CLK_PRE_UI    = 8;
  localparam int T_HS_PZ_NS      = 145;
  localparam int T_HS_PZ_UI      = 10;
  localparam int T_HS_TRAIL_NS   = 60;
  localparam int T_HS_TRAIL_UI   = 4;
  localparam int T_EOT_NS        = 105;
  localparam int T_EOT_UI        = 12;
  localparam int T_CLK_POST_NS   = 60;
  localparam int T_CLK_POST_UI   = 52;
  localparam int T_CLK_TRAIL_NS  = 60;
  localparam int T_HS_EXIT_NS    = 100;
  localparam int T_ULPS_REC_MS   = 1;

  // Least time: round up, never below one cycle.
  function automatic int cyc_min(input int ns, input int ui);
    int c;
    c = (ns * 1000 + ui * UI_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down, never below one cycle.
  function automatic int cyc_max(input int ns, input int ui);
    int c;
    c = (ns * 1000 + ui * UI_PS) / LINK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int LPX_I   = cyc_min(T_LPX_NS, 0);
  localparam int CPREP_I = cyc_min(T_CLK_PREP_NS, 0);
  localparam int CPZ_I   = cyc_min(T_CLK_PZ_NS, 0);
  localparam int CZERO_I = (CPZ_I > CPREP_I) ? CPZ_I - CPREP_I : 1;
  localparam int TRL_I   = cyc_min(T_HS_TRAIL_NS, T_HS_TRAIL_UI);
  localparam int EOT_I   = cyc_max(T_EOT_NS, T_EOT_UI);
  localparam int REC_I   = cyc_min(T_ULPS_REC_MS * 1000000, 0);

  localparam logic [TMR_W-1:0] LPX_CYC = TMR_W'(LPX_I);
  localparam logic [TMR_W-1:0] CLK_PREP_CYC = TMR_W'(CPREP_I);
  localparam logic [TMR_W-1:0] CLK_ZERO_CYC = TMR_W'(CZERO_I);
  localparam logic [TMR_W-1:0] CLK_PRE_CYC =
    TMR_W'(cyc_min(0, T_CLK_PRE_UI));
  localparam logic [TMR_W-1:0] HS_PZ_CYC =
    TMR_W'(cyc_min(T_HS_PZ_NS, T_HS_PZ_UI));
  // The trail must also finish inside the end-of-burst limit.
  localparam logic [TMR_W-1:0] HS_TRAIL_CYC =
    TMR_W'((TRL_I < EOT_I) ? TRL_I : EOT_I);
  localparam logic [TMR_W-1:0] CLK_POST_CYC =
    TMR_W'(cyc_min(T_CLK_POST_NS, T_CLK_POST_UI));
  localparam logic [TMR_W-1:0] CLK_TRAIL_CYC =
    TMR_W'(cyc_min(T_CLK_TRAIL_NS, 0));
  localparam logic [TMR_W-1:0] HS_EXIT_CYC =
    TMR_W'(cyc_min(T_HS_EXIT_NS, 0));

  // Lane geometry.
  localparam int NUM_DLANES = 8;
  localparam int NUM_CLANES = 2;
  localparam int GRP_LANES  = 4;

  // Low-power line codes, positive wire first.
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [7:0] SYNC_BYTE = 8'hb8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Pixel clock window in MHz for one and two serial lanes.
  localparam logic [7:0] PCLK1_MIN = 8'h19;
  localparam logic [7:0] PCLK1_MAX = 8'h60;
  localparam logic [7:0] PCLK2_MIN = 8'h32;
  localparam logic [7:0] PCLK2_MAX = 8'haa;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'h00,
    ST_CLK_LP01  = 5'h01,
    ST_CLK_LP00  = 5'h03,
    ST_CLK_PREP  = 5'h02,
    ST_CLK_ZERO  = 5'h06,
    ST_CLK_PRE   = 5'h07,
    ST_D_LP01    = 5'h05,
    ST_D_LP00    = 5'h04,
    ST_D_HSZERO  = 5'h0c,
    ST_D_SYNC    = 5'h0d,
    ST_D_PAY     = 5'h0f,
    ST_D_TRAIL   = 5'h0e,
    ST_CLK_POST  = 5'h0a,
    ST_CLK_TRAIL = 5'h0b,
    ST_HS_EXIT   = 5'h09,
    ST_ULPS      = 5'h10,
    ST_ULPS_WAKE = 5'h11,
    ST_RECOVER   = 5'h13
  } csq_state_t;

  typedef struct packed {
    logic [1:0] lp;
    logic       hs_en;
    logic [7:0] hs_byte;
  } csq_dlane_t;

  typedef struct packed {
    logic [1:0] lp;
    logic       hs_en;
    logic       clk_run;
  } csq_clane_t;

  typedef struct packed {
    logic pclk_ok;
    logic ulps;
    logic busy;
  } csq_ref_t;

  typedef struct packed {
    csq_state_t                   st;
    logic [TMR_W-1:0]             tmr;
    csq_clane_t [NUM_CLANES-1:0]  cl;
    csq_dlane_t [NUM_DLANES-1:0]  dl;
  } csq_link_t;

endpackage
`default_nettype wire

/* File: core/csq_sync.sv */
// Two-flop level synchroniser for a group of independent level signals.
// Assumes each bit is a slow level; words that must arrive together need
// a handshake instead.
`timescale 1ns/1ps
`default_nettype none
module csq_sync #(
  parameter int W = 1
) (
  // Clock of the receiving domain
  input  wire logic         clk_in,
  // Level from the other domain, and its synchronised copy
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csq_sync_t;

  csq_sync_t sync_reg;
  csq_sync_t sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d_in;
    sync_next.s2 = sync_reg.s1;
  end

  // No reset: a synchroniser must settle whatever its inputs do.
  always_ff @(posedge clk_in) begin
    sync_reg <= sync_next;
  end

  assign q_out = sync_reg.s2;

endmodule
`default_nettype wire

/* File: core/csq_lane_seq.sv */
// Lane sequencer for a camera-link high-speed output: one or two clock
// lanes and up to eight data lanes with low-power entry and exit.
// Assumes a byte clock on link_clk_in, a 250 MHz control clock on
// ref_clk_in and a payload source that lives in the byte-clock domain.
//
// Behaviour
// - The clock lane stays in HS-0 for at least 60 ns after the last payload clock before leaving high speed.
// - Clock prepare plus clock HS-0 zero together last at least 300 ns before the clock starts toggling.
// - LP-11 is reached within 105 ns plus 12 UI from the start of the data trail.
// - After each burst all lanes rest in LP-11 for at least 100 ns before a new entry begins.
// - Data prepare plus HS-0 zero last at least 145 ns plus 10 UI before the sync byte.
// - Each low-power state of an entry or exit sequence lasts at least 50 ns.
// - After leaving ultra-low-power state the lanes wait 1 ms before high-speed traffic resumes.
// - Two or four data lanes and one clock lane, or in replicate mode twice as many data lanes and two clock lanes with duplicated content.
// - The pixel clock must lie in 25 to 96 MHz with one serial lane or 50 to 170 MHz with two.
// - The high-speed clock runs at least 8 UI before any data lane begins its entry.
`timescale 1ns/1ps
`default_nettype none
module csq_lane_seq #(
  parameter int ULPS_REC_CYC = csq_pkg::REC_I
) (
  // Control clock, synchronous active-high reset, clock enable
  input  wire logic                   ref_clk_in,
  input  wire logic                   srst_in,
  input  wire logic                   clk_en_in,
  // Byte clock of the lane logic
  input  wire logic                   link_clk_in,
  // Configuration, control clock domain
  input  wire logic                   four_lane_in,
  input  wire logic                   replicate_in,
  input  wire logic                   ulps_req_in,
  input  wire logic                   two_serial_in,
  input  wire logic [7:0]             pclk_mhz_in,
  // Status, control clock domain
  output logic                        pclk_ok_out,
  output logic                        ulps_active_out,
  output logic                        burst_busy_out,
  // Payload, byte clock domain
  input  wire logic                   pl_valid_in,
  input  wire logic                   pl_last_in,
  input  wire logic [31:0]            pl_data_in,
  output logic                        pl_ready_out,
  // Lane drive, byte clock domain
  output csq_pkg::csq_clane_t [1:0]   clk_lane_out,
  output csq_pkg::csq_dlane_t [7:0]   data_lane_out
);
  import csq_pkg::*;

  localparam logic [TMR_W-1:0] REC_CYC = TMR_W'(ULPS_REC_CYC);

  csq_ref_t  ref_reg;
  csq_ref_t  ref_next;
  csq_link_t link_reg;
  csq_link_t link_next;

  logic [4:0] cfg_sync;
  logic [1:0] stat_sync;
  logic       lrst;
  logic       len;
  logic       four_s;
  logic       rep_s;
  logic       ulps_s;
  logic       take;

  // Configuration levels into the byte clock domain.
  csq_sync #(.W(5)) u_cfg_sync (
    .clk_in (link_clk_in),
    .d_in   ({srst_in, clk_en_in, ulps_req_in, replicate_in,
              four_lane_in}),
    .q_out  (cfg_sync)
  );

  // Lane status back into the control clock domain.
  csq_sync #(.W(2)) u_stat_sync (
    .clk_in (ref_clk_in),
    .d_in   ({link_reg.st == ST_ULPS,
              link_reg.st != ST_IDLE && link_reg.st != ST_ULPS &&
              link_reg.st != ST_ULPS_WAKE &&
              link_reg.st != ST_RECOVER}),
    .q_out  (stat_sync)
  );

  assign lrst   = cfg_sync[4];
  assign len    = cfg_sync[3];
  assign ulps_s = cfg_sync[2];
  assign rep_s  = cfg_sync[1];
  assign four_s = cfg_sync[0];

  function automatic logic in_rng(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Control clock domain: pixel clock check and status.
  always_comb begin
    ref_next = ref_reg;
    if (clk_en_in) begin
      if (two_serial_in) begin
        ref_next.pclk_ok = in_rng(pclk_mhz_in, PCLK2_MIN, PCLK2_MAX);
      end else begin
        ref_next.pclk_ok = in_rng(pclk_mhz_in, PCLK1_MIN, PCLK1_MAX);
      end
      ref_next.ulps = stat_sync[1];
      ref_next.busy = stat_sync[0];
    end
    if (srst_in) begin
      ref_next = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    ref_reg <= ref_next;
  end

  assign pclk_ok_out     = ref_reg.pclk_ok;
  assign ulps_active_out = ref_reg.ulps;
  assign burst_busy_out  = ref_reg.busy;

  // Time spent in a state, less one, in byte clocks.
  function automatic logic [TMR_W-1:0] dur_m1(input csq_state_t s);
    logic [TMR_W-1:0] d;
    d = TMR_W'(1);
    unique case (s)
      ST_CLK_LP01, ST_CLK_LP00,
      ST_D_LP01, ST_D_LP00,
      ST_ULPS, ST_ULPS_WAKE: d = LPX_CYC;
      ST_CLK_PREP:  d = CLK_PREP_CYC;
      ST_CLK_ZERO:  d = CLK_ZERO_CYC;
      ST_CLK_PRE:   d = CLK_PRE_CYC;
      ST_D_HSZERO:  d = HS_PZ_CYC;
      ST_D_TRAIL:   d = HS_TRAIL_CYC;
      ST_CLK_POST:  d = CLK_POST_CYC;
      ST_CLK_TRAIL: d = CLK_TRAIL_CYC;
      ST_HS_EXIT:   d = HS_EXIT_CYC;
      ST_RECOVER:   d = REC_CYC;
      default:      d = TMR_W'(1);
    endcase
    return d - TMR_W'(1);
  endfunction

  assign pl_ready_out = (link_reg.st == ST_D_PAY) && len && !lrst;
  assign take         = pl_ready_out && pl_valid_in;

  // Byte clock domain: lane state machine and registered lane drive.
  always_comb begin
    logic       done;
    logic       on;
    logic [1:0] g;
    done      = 1'b0;
    on        = 1'b0;
    g         = 2'h0;
    link_next = link_reg;
    done      = (link_reg.tmr == '0);
    if (!done) begin
      link_next.tmr = link_reg.tmr - TMR_W'(1);
    end
    unique case (link_reg.st)
      ST_IDLE: begin
        if (ulps_s) begin
          link_next.st = ST_ULPS;
        end else if (pl_valid_in) begin
          link_next.st = ST_CLK_LP01;
        end
      end
      ST_CLK_LP01: if (done) link_next.st = ST_CLK_LP00;
      ST_CLK_LP00: if (done) link_next.st = ST_CLK_PREP;
      ST_CLK_PREP: if (done) link_next.st = ST_CLK_ZERO;
      ST_CLK_ZERO: if (done) link_next.st = ST_CLK_PRE;
      ST_CLK_PRE:  if (done) link_next.st = ST_D_LP01;
      ST_D_LP01:   if (done) link_next.st = ST_D_LP00;
      ST_D_LP00:   if (done) link_next.st = ST_D_HSZERO;
      ST_D_HSZERO: if (done) link_next.st = ST_D_SYNC;
      ST_D_SYNC:   link_next.st = ST_D_PAY;
      ST_D_PAY: begin
        // A source that drops valid mid-burst ends the burst here.
        if (!pl_valid_in || pl_last_in) begin
          link_next.st = ST_D_TRAIL;
        end
      end
      ST_D_TRAIL:   if (done) link_next.st = ST_CLK_POST;
      ST_CLK_POST:  if (done) link_next.st = ST_CLK_TRAIL;
      ST_CLK_TRAIL: if (done) link_next.st = ST_HS_EXIT;
      ST_HS_EXIT:   if (done) link_next.st = ST_IDLE;
      ST_ULPS: begin
        if (done && !ulps_s) begin
          link_next.st = ST_ULPS_WAKE;
        end
      end
      ST_ULPS_WAKE: if (done) link_next.st = ST_RECOVER;
      ST_RECOVER:   if (done) link_next.st = ST_IDLE;
      default:      link_next.st = ST_IDLE;
    endcase
    if (link_next.st != link_reg.st) begin
      link_next.tmr = dur_m1(link_next.st);
    end

    // Clock lanes follow the state; the second only in replicate mode.
    for (int c = 0; c < NUM_CLANES; c++) begin
      on = (c == 0) || rep_s;
      link_next.cl[c] = '{lp: LP11, hs_en: 1'b0, clk_run: 1'b0};
      if (on) begin
        unique case (link_reg.st)
          ST_CLK_LP01: link_next.cl[c].lp = LP01;
          ST_CLK_LP00: link_next.cl[c].lp = LP00;
          ST_CLK_PREP, ST_CLK_ZERO, ST_CLK_TRAIL: begin
            link_next.cl[c].lp    = LP00;
            link_next.cl[c].hs_en = 1'b1;
          end
          ST_CLK_PRE, ST_D_LP01, ST_D_LP00, ST_D_HSZERO,
          ST_D_SYNC, ST_D_PAY, ST_D_TRAIL, ST_CLK_POST: begin
            link_next.cl[c].lp      = LP00;
            link_next.cl[c].hs_en   = 1'b1;
            link_next.cl[c].clk_run = 1'b1;
          end
          ST_ULPS:      link_next.cl[c].lp = LP00;
          ST_ULPS_WAKE: link_next.cl[c].lp = LP10;
          default:      link_next.cl[c].lp = LP11;
        endcase
      end
    end

    // Data lanes: lanes 2 and 3 of each group only in four-lane mode,
    // the second group only in replicate mode with the same bytes.
    for (int i = 0; i < NUM_DLANES; i++) begin
      g  = 2'(i % GRP_LANES);
      on = (four_s || !g[1]) && (i < GRP_LANES || rep_s);
      if (!on) begin
        link_next.dl[i] = '{lp: LP11, hs_en: 1'b0, hs_byte: ZERO_BYTE};
      end else begin
        unique case (link_reg.st)
          ST_D_LP01: begin
            link_next.dl[i] = '{lp: LP01, hs_en: 1'b0,
                                hs_byte: ZERO_BYTE};
          end
          ST_D_LP00: begin
            link_next.dl[i] = '{lp: LP00, hs_en: 1'b0,
                                hs_byte: ZERO_BYTE};
          end
          ST_D_HSZERO: begin
            link_next.dl[i] = '{lp: LP00, hs_en: 1'b1,
                                hs_byte: ZERO_BYTE};
          end
          ST_D_SYNC: begin
            link_next.dl[i] = '{lp: LP00, hs_en: 1'b1,
                                hs_byte: SYNC_BYTE};
          end
          ST_D_PAY: begin
            link_next.dl[i].lp    = LP00;
            link_next.dl[i].hs_en = 1'b1;
            if (take) begin
              link_next.dl[i].hs_byte = pl_data_in[8*g +: 8];
            end else begin
              // Trail drives the inverse of the last bit sent.
              link_next.dl[i].hs_byte =
                {8{~link_reg.dl[i].hs_byte[7]}};
            end
          end
          ST_D_TRAIL: begin
            if (link_reg.tmr == HS_TRAIL_CYC - TMR_W'(1) &&
                !link_reg.dl[i].hs_en) begin
              link_next.dl[i].hs_byte = ZERO_BYTE;
            end
            link_next.dl[i].hs_en = 1'b1;
            link_next.dl[i].lp    = LP00;
          end
          ST_ULPS: begin
            link_next.dl[i] = '{lp: LP00, hs_en: 1'b0,
                                hs_byte: ZERO_BYTE};
          end
          ST_ULPS_WAKE: begin
            link_next.dl[i] = '{lp: LP10, hs_en: 1'b0,
                                hs_byte: ZERO_BYTE};
          end
          default: begin
            link_next.dl[i] = '{lp: LP11, hs_en: 1'b0,
                                hs_byte: ZERO_BYTE};
          end
        endcase
      end
    end

    if (!len) begin
      link_next = link_reg;
    end
    if (lrst) begin
      link_next.st  = ST_IDLE;
      link_next.tmr = '0;
      for (int c = 0; c < NUM_CLANES; c++) begin
        link_next.cl[c] = '{lp: LP11, hs_en: 1'b0, clk_run: 1'b0};
      end
      for (int i = 0; i < NUM_DLANES; i++) begin
        link_next.dl[i] = '{lp: LP11, hs_en: 1'b0, hs_byte: ZERO_BYTE};
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    link_reg <= link_next;
  end

  assign clk_lane_out  = link_reg.cl;
  assign data_lane_out = link_reg.dl;

endmodule
`default_nettype wire

/* File: sim/csq_lane_seq_chk.sv */
// Assertions on the lane drive of the lane sequencer, byte clock domain.
// Assumes the ports of the top module only; bound to it at the foot.
`timescale 1ns/1ps
`default_nettype none
module csq_chk #(
  parameter int ULPS_REC_CYC = csq_pkg::REC_I
) (
  // Byte clock and reset
  input wire logic                      link_clk_in,
  input wire logic                      srst_in,
  // Watched outputs
  input wire logic                      pl_ready_out,
  input wire csq_pkg::csq_clane_t [1:0] clk_lane_out,
  input wire csq_pkg::csq_dlane_t [7:0] data_lane_out
);
  import csq_pkg::*;
  csq_clane_t c;
  csq_dlane_t d;
  int         dr_reg;
  int         cz_reg;
  int         dz_reg;
  int         rn_reg;
  int         tr_reg;
  int         c11_reg;
  int         ur_reg;
  assign c = clk_lane_out[0];
  assign d = data_lane_out[0];
  // Run lengths in byte clocks; each holds the count up to the last edge.
  always_ff @(posedge link_clk_in) begin
    if (srst_in) begin
      dr_reg  <= 1;
      cz_reg  <= 0;
      dz_reg  <= 0;
      rn_reg  <= 0;
      tr_reg  <= 0;
      c11_reg <= 0;
      ur_reg  <= ULPS_REC_CYC;
    end else begin
      dr_reg  <= (d.lp != $past(d.lp)) ? 1 : dr_reg + 1;
      cz_reg  <= (c.lp == LP01) ? 0 : (c.clk_run ? cz_reg : cz_reg + 1);
      dz_reg  <= (d.lp == LP01) ? 0 : dz_reg + 1;
      rn_reg  <= c.clk_run ? rn_reg + 1 : 0;
      tr_reg  <= c.clk_run ? 0 : (c.hs_en ? tr_reg + 1 : tr_reg);
      c11_reg <= (c.lp == LP11 && !c.hs_en) ? c11_reg + 1 : 0;
      ur_reg  <= (c.lp == LP10 || d.lp == LP10) ? 0 : ur_reg + 1;
    end
  end
  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (srst_in);
  chk_lp_order: assert property (
    $past(d.lp) == LP01 && d.lp != LP01 |-> d.lp == LP00)
    else $error("data lane left LP-01 for a wrong state");
  chk_lpx_hold: assert property (
    (d.lp != $past(d.lp) || d.hs_en) && !$past(d.hs_en)
    && $past(d.lp) != LP11 |-> dr_reg >= LPX_CYC)
    else $error("low-power state held too briefly");
  chk_clk_zero: assert property (
    $rose(c.clk_run) |-> cz_reg >= CLK_PREP_CYC + CLK_ZERO_CYC)
    else $error("clock started before prepare and zero ran out");
  chk_data_zero: assert property (
    d.hs_en && d.hs_byte == SYNC_BYTE |-> dz_reg >= HS_PZ_CYC)
    else $error("sync byte came before prepare and zero ran out");
  chk_clk_pre: assert property (
    $past(d.lp) == LP11 && d.lp == LP01 |-> rn_reg >= CLK_PRE_CYC)
    else $error("data entry began before the clock ran long enough");
  chk_clk_trail: assert property (
    $fell(c.hs_en) |-> tr_reg >= CLK_TRAIL_CYC && !d.hs_en)
    else $error("clock lane left high speed too early");
  chk_eot_limit: assert property (
    $fell(pl_ready_out) |-> ##[1:2] (d.lp == LP11 && !d.hs_en))
    else $error("data lane missed LP-11 after the trail");
  chk_exit_rest: assert property (
    $past(c.lp) == LP11 && c.lp == LP01 |-> c11_reg >= HS_EXIT_CYC)
    else $error("new entry began before LP-11 rest ran out");
  chk_ulps_rec: assert property (
    $past(c.lp) == LP11 && c.lp == LP01 |-> ur_reg >= ULPS_REC_CYC)
    else $error("entry began before ultra-low-power recovery");
  chk_replica: assert property (
    data_lane_out[4].hs_en |-> data_lane_out[4] == data_lane_out[0])
    else $error("replicated lane differs from its source");
endmodule
bind csq_lane_seq csq_chk #(.ULPS_REC_CYC(ULPS_REC_CYC)) u_csq_chk (
  .link_clk_in  (link_clk_in),
  .srst_in      (srst_in),
  .pl_ready_out (pl_ready_out),
  .clk_lane_out (clk_lane_out),
  .data_lane_out(data_lane_out)
);
`default_nettype wire

/* File: sim/csq_rx_model.sv */
// Receiver model for one data lane of the camera link output.
// Assumes it only listens: the receiver never drives the lanes.
`timescale 1ns/1ps
`default_nettype none
module csq_rx_model (
  // Byte clock and observed lane
  input  wire logic                link_clk_in,
  input  wire csq_pkg::csq_dlane_t lane_in,
  // Bursts whose first non-zero byte was the sync byte
  output var int                   bursts_out
);
  import csq_pkg::*;
  logic hunt_reg;
  initial begin
    bursts_out = 0;
    hunt_reg = 1'b0;
  end
  always @(posedge link_clk_in) begin
    if (lane_in.lp == LP00 && !lane_in.hs_en) hunt_reg <= 1'b1;
    if (hunt_reg && lane_in.hs_en && lane_in.hs_byte != ZERO_BYTE) begin
      hunt_reg <= 1'b0;
      if (lane_in.hs_byte == SYNC_BYTE) bursts_out <= bursts_out + 1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench: pixel clock window, bursts in two-lane, four-lane and four-lane replicate mode, an
// aborted burst and ultra-low-power entry and exit with recovery.
// Assumes the checker is bound to the design and a receiver model listens.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import csq_pkg::*;
  localparam logic [7:0] PT [8] = '{8'h18, 8'h19, 8'h60, 8'h61,
                                   8'h31, 8'h32, 8'haa, 8'hab};
  logic             ref_clk_in = 1'b0;
  logic             link_clk_in = 1'b0;
  logic             srst_in = 1'b1;
  logic             four_lane_in = 1'b1;
  logic             replicate_in = 1'b0;
  logic             ulps_req_in = 1'b0;
  logic             two_serial_in = 1'b0;
  logic [7:0]       pclk_mhz_in = 8'h30;
  logic             pl_valid_in = 1'b0;
  logic             pl_last_in = 1'b0;
  logic [31:0]      pl_data_in = 32'h0;
  logic             pclk_ok_out;
  logic             ulps_active_out;
  logic             burst_busy_out;
  logic             pl_ready_out;
  csq_clane_t [1:0] clk_lane_out;
  csq_dlane_t [7:0] data_lane_out;
  int               n_errors = 0;
  int               n_tests = 0;
  int               seed = 75607;
  int               bursts;
  int               nbursts = 0;
  logic [31:0]      expq [$];
  logic [31:0]      w;
  bit               pend = 1'b0;

  always #2 ref_clk_in = ~ref_clk_in;
  always #62.5 link_clk_in = ~link_clk_in;

  // The short recovery count keeps the run brief; the checker gets it too.
  csq_lane_seq #(.ULPS_REC_CYC(20)) u_csq_lane_seq (
    .ref_clk_in, .srst_in, .clk_en_in(1'b1), .link_clk_in, .four_lane_in,
    .replicate_in, .ulps_req_in, .two_serial_in, .pclk_mhz_in, .pclk_ok_out,
    .ulps_active_out, .burst_busy_out, .pl_valid_in, .pl_last_in,
    .pl_data_in, .pl_ready_out, .clk_lane_out, .data_lane_out);
  csq_rx_model u_csq_rx_model (
    .link_clk_in, .lane_in(data_lane_out[0]), .bursts_out(bursts));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bench model: every taken word must show on each active lane next edge.
  always @(posedge link_clk_in) begin
    if (pend) begin
      w = expq.pop_front();
      for (int g = 0; g < (four_lane_in ? 4 : 2); g++) begin
        check({data_lane_out[g].hs_en, data_lane_out[g].hs_byte},
              {1'b1, w[8*g+:8]});
        if (replicate_in) check(data_lane_out[g+4].hs_byte, w[8*g+:8]);
      end
      if (replicate_in) check(clk_lane_out[1], clk_lane_out[0]);
    end
    pend = pl_ready_out && pl_valid_in;
    if (pend) expq.push_back(pl_data_in);
  end

  task automatic burst(input int n, input bit abort);
    int t;
    @(posedge link_clk_in);
    pl_valid_in <= 1'b1;
    pl_data_in <= $random(seed);
    pl_last_in <= (n == 1) && !abort;
    for (int i = 0; i < n; i++) begin
      t = 0;
      do begin
        @(posedge link_clk_in);
        t++;
      end while (pl_ready_out !== 1'b1 && t < 100);
      if (t >= 100) n_errors++;
      pl_data_in <= $random(seed);
      pl_last_in <= (i == n - 2) && !abort;
      if (i == n - 1) pl_valid_in <= 1'b0;
    end
  endtask

  task automatic settle();
    int t;
    t = 0;
    check(burst_busy_out, 1'b1);
    while (burst_busy_out !== 1'b0 && t < 5000) begin
      @(posedge ref_clk_in);
      t++;
    end
    check(burst_busy_out, 1'b0);
    repeat (2) @(posedge link_clk_in);
    nbursts++;
    check(bursts, nbursts);
    for (int g = 0; g < 8; g++)
      check({data_lane_out[g].lp, data_lane_out[g].hs_en},
            {LP11, 1'b0});
  endtask

  task automatic wait_ulps(input logic v);
    int t;
    t = 0;
    while (ulps_active_out !== v && t < 2000) begin
      @(posedge ref_clk_in);
      t++;
    end
    check(ulps_active_out, v);
  endtask

  initial begin
    logic [7:0] m;
    bit         s;
    // The link domain sees reset late, so it is held over several byte clocks.
    repeat (5) @(posedge link_clk_in);
    @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge link_clk_in);
    check({clk_lane_out[0].lp, clk_lane_out[0].hs_en, data_lane_out[0].lp,
           data_lane_out[0].hs_en, pl_ready_out},
          {LP11, 1'b0, LP11, 2'h0});
    for (int k = 0; k < 16; k++) begin
      s = (k < 8) ? (k >= 4) : $random(seed);
      m = (k < 8) ? PT[k] : 8'($random(seed));
      @(posedge ref_clk_in);
      two_serial_in <= s;
      pclk_mhz_in <= m;
      repeat (10) @(posedge ref_clk_in);
      check(pclk_ok_out,
            s ? (m >= 50 && m <= 170) : (m >= 25 && m <= 96));
    end
    // A 25 MHz source on one serial lane must be accepted.
    @(posedge ref_clk_in);
    two_serial_in <= 1'b0;
    pclk_mhz_in   <= 8'h19;
    repeat (3) @(posedge ref_clk_in);
    check(pclk_ok_out, 1'b1);
    for (int md = 0; md < 4; md++) begin
      @(posedge ref_clk_in);
      four_lane_in <= (md != 1);
      replicate_in <= (md >= 2);
      repeat (4) @(posedge link_clk_in);
      burst(1, 1'b0);
      settle();
      burst(2 + ($unsigned($random(seed)) % 4), md == 3);
      settle();
    end
    @(posedge ref_clk_in);
    ulps_req_in <= 1'b1;
    wait_ulps(1'b1);
    check({clk_lane_out[0].hs_en, data_lane_out[0].hs_en}, 2'h0);
    ulps_req_in <= 1'b0;
    wait_ulps(1'b0);
    burst(3, 1'b0);
    settle();
    summarize();
  end

  initial begin
    #300000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
